// *** hdl/etx_pkg.sv ***
package etx_pkg;
  // Clocking and line timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int BIT_HZ      = 10_000_000;
  localparam int BIT_CYC     = CLK_HZ / BIT_HZ;
  localparam int HALF_CYC    = (BIT_CYC + 1) / 2;
  localparam int IFG_NS      = 9600;
  localparam int IFG_CYC     = (IFG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SLOT_NS     = 51200;
  localparam int SLOT_CYC    = (SLOT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Frame layout, retry and backoff limits
  localparam int PRE_BITS    = 64;
  localparam int JAM_BITS    = 40;
  localparam int MAX_TRIES   = 16;
  localparam int BO_CAP      = 10;
  localparam int SRC_FIRST   = 6;
  localparam int SRC_LAST    = 11;
  localparam int MIN_BODY    = 60;
  localparam int MAX_FRAME   = 1518;
  localparam int FCS_BYTES   = 4;
  localparam int MAX_BODY    = MAX_FRAME - FCS_BYTES;
  localparam int FCS_BITS    = 32;
  // Storage
  localparam int BUF_BYTES   = 1536;
  localparam int LEN_W       = 11;
  localparam int FIFO_DEPTH  = 8;
  localparam int ADDR_W      = 24;
  localparam int CNT_W       = 12;
  localparam int IE_W        = 3;
  // Codes
  localparam logic [2:0] IE_OFF     = 3'h0;
  localparam logic [2:0] IE_TX_DMA  = 3'h6;
  localparam logic [7:0] CMD_SEND   = 8'h29;
  localparam logic [7:0] CMD_SRC_ON = 8'h2a;
  localparam logic [7:0] CMD_SRC_OFF = 8'h2b;
  localparam logic [7:0] ST_OK      = 8'h00;
  localparam logic [7:0] ST_TOO_BIG = 8'h05;
  localparam logic [7:0] ST_RETRIES = 8'h06;
  // CRC and random source
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  localparam logic [15:0] LFSR_SEED   = 16'hace1;
  // Transmit sequencer, Gray from idle up to FCS; FCS back to idle flips two bits
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEFER = 3'b001,
    ST_PRE   = 3'b011,
    ST_DATA  = 3'b010,
    ST_FCS   = 3'b110,
    ST_JAM   = 3'b111,
    ST_BACK  = 3'b101
  } tx_state_t;
endpackage

// *** hdl/ethernet_transmit_mac.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage input filter; value moves once stages two and three agree
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic [2:0] sh_r;   // Stage one only feeds stage two
  logic       q_r;
  logic       q_nxt;

  // Next stable value
  always_comb begin
    q_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : q_r;
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_r <= 3'h0;
      q_r  <= 1'b0;
    end else begin
      sh_r <= {sh_r[1:0], d_i};
      q_r  <= q_nxt;
    end
  end
  assign q_o = q_r;
endmodule

// Flip-flop FIFO between DMA fetch and the packet buffer
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0]      wp_r, wp_nxt;   // Extra bit tells full from empty
  logic [PW:0]      rp_r, rp_nxt;
  logic             push, pop;

  assign in_ready_o  = (wp_r ^ rp_r) != {1'b1, {PW{1'b0}}};
  assign out_valid_o = wp_r != rp_r;
  assign out_data_o  = mem_r[rp_r[PW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer advance
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  // Pointers and storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      if (push) begin
        mem_r[wp_r[PW-1:0]] <= in_data_i;
      end
    end
  end
endmodule

module ethernet_transmit_mac (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Host register writes
  input  wire logic [7:0]  reg_data_i,
  input  wire logic        int_enable_wr_i,
  input  wire logic        dma_addr_upper_reg_wr_i,
  input  wire logic        dma_addr_middle_reg_wr_i,
  input  wire logic        dma_addr_lower_reg_wr_i,
  input  wire logic        dma_count_high_reg_wr_i,
  input  wire logic        dma_count_low_reg_wr_i,
  input  wire logic        cmd_wr_i,
  input  wire logic        status_rd_i,
  input  wire logic [47:0] station_addr_i,
  // Host status
  output logic             tx_dma_done_irq_o,
  output logic [7:0]       status_o,
  output logic             status_full_o,
  output logic             src_autofill_o,
  // Host memory DMA
  output logic             dma_req_o,
  output logic [23:0]      dma_addr_o,
  input  wire logic        dma_ack_i,
  input  wire logic [7:0]  dma_data_i,
  // Network transceiver
  input  wire logic        carrier_i,
  input  wire logic        collision_i,
  output logic             tx_o,
  output logic             tx_en_o,
  // Receive bit stream from the decoder
  input  wire logic        rx_sof_i,
  input  wire logic        rx_bit_vld_i,
  input  wire logic        rx_bit_i,
  output logic             rx_crc_ok_o
);
  // One serial CRC step, reflected form
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? etx_pkg::CRC_POLY : 32'h0);
  endfunction

  // DMA and host register state
  logic [23:0] addr_r, addr_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic        dma_on_r, dma_on_nxt;
  logic        irq_r, irq_nxt;
  logic        auto_r, auto_nxt;
  logic [7:0]  stat_r, stat_nxt;
  logic        sfull_r, sfull_nxt;
  // FIFO links
  logic        f_in_rdy, f_out_vld, f_out_rdy;
  logic [7:0]  f_out_data;
  // Packet buffer
  logic [7:0]  buf_r [etx_pkg::BUF_BYTES];
  logic [10:0] blen_r, blen_nxt;
  logic        buf_wr;
  // Transmit sequencer
  etx_pkg::tx_state_t st_r, st_nxt;
  logic [11:0] tmr_r, tmr_nxt;     // Gap and slot timer
  logic [2:0]  ph_r, ph_nxt;       // Cycle within a bit cell
  logic [10:0] idx_r, idx_nxt;     // Body byte index
  logic [2:0]  k_r, k_nxt;         // Bit within byte
  logic [6:0]  bitn_r, bitn_nxt;   // Preamble, FCS and jam bit count
  logic [4:0]  tries_r, tries_nxt;
  logic [9:0]  slots_r, slots_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic        tx_r, tx_nxt, txen_r, txen_nxt;
  // Helpers
  logic        carrier_s, coll_s, tick, active, cur_bit;
  logic [7:0]  cur_byte;
  logic [10:0] body_len;
  logic [3:0]  bo_k;

  pin_sync u_carrier (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (carrier_i),
    .q_o     (carrier_s)
  );
  pin_sync u_collision (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (collision_i),
    .q_o     (coll_s)
  );

  // Fetched bytes wait here; the buffer only fills while idle
  tx_fifo #(
    .WIDTH (8),
    .DEPTH (etx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (dma_req_o && dma_ack_i),
    .in_ready_o  (f_in_rdy),
    .in_data_i   (dma_data_i),
    .out_valid_o (f_out_vld),
    .out_ready_i (f_out_rdy),
    .out_data_o  (f_out_data)
  );

  // Request only with room, so an ack is never lost
  assign dma_req_o = dma_on_r && (cnt_r != 12'h0) && f_in_rdy;
  assign f_out_rdy = (st_r == etx_pkg::ST_IDLE);
  assign buf_wr    = f_out_vld && f_out_rdy && (blen_r != 11'(etx_pkg::BUF_BYTES));

  // Host registers and DMA pacing
  always_comb begin
    addr_nxt   = addr_r;
    cnt_nxt    = cnt_r;
    dma_on_nxt = dma_on_r;
    irq_nxt    = irq_r;
    if (dma_addr_upper_reg_wr_i) begin
      addr_nxt[23:16] = reg_data_i;
    end
    if (dma_addr_middle_reg_wr_i) begin
      addr_nxt[15:8] = reg_data_i;
    end
    if (dma_addr_lower_reg_wr_i) begin
      addr_nxt[7:0] = reg_data_i;
    end
    if (dma_count_high_reg_wr_i) begin
      cnt_nxt[11:8] = reg_data_i[3:0];
    end
    if (dma_count_low_reg_wr_i) begin
      cnt_nxt[7:0] = reg_data_i;
    end
    // A code write drops the line unless the done check below sets it that cycle; only code 6 runs the transmit DMA
    if (int_enable_wr_i) begin
      irq_nxt    = 1'b0;
      dma_on_nxt = (reg_data_i[etx_pkg::IE_W-1:0] == etx_pkg::IE_TX_DMA);
    end
    if (dma_req_o && dma_ack_i) begin
      addr_nxt = addr_r + 24'h1;
      cnt_nxt  = cnt_r - 12'h1;
    end
    // Done once the count is spent and no byte is still in flight
    if (dma_on_r && (cnt_r == 12'h0) && !f_out_vld) begin
      irq_nxt    = 1'b1;
      dma_on_nxt = 1'b0;
    end
  end

  // Current byte and bit of the frame
  always_comb begin
    body_len = (blen_r < 11'(etx_pkg::MIN_BODY)) ? 11'(etx_pkg::MIN_BODY) : blen_r;
    if (auto_r && idx_r >= 11'(etx_pkg::SRC_FIRST) && idx_r <= 11'(etx_pkg::SRC_LAST)) begin
      cur_byte = station_addr_i[8*(etx_pkg::SRC_LAST-int'(idx_r)) +: 8];
    end else if (idx_r < blen_r) begin
      // Destination goes out as stored, so broadcast and group bits pass untouched
      cur_byte = buf_r[idx_r];
    end else begin
      cur_byte = 8'h00;
    end
    case (st_r)
      etx_pkg::ST_PRE: begin
        // Alternating ones and zeros, closing with two ones
        cur_bit = (bitn_r >= 7'(etx_pkg::PRE_BITS - 2)) || !bitn_r[0];
      end
      etx_pkg::ST_DATA: begin
        cur_bit = cur_byte[k_r];
      end
      etx_pkg::ST_FCS: begin
        cur_bit = !crc_r[0];
      end
      default: begin
        cur_bit = 1'b0;
      end
    endcase
  end

  assign active = (st_r == etx_pkg::ST_PRE) || (st_r == etx_pkg::ST_DATA) ||
                  (st_r == etx_pkg::ST_FCS) || (st_r == etx_pkg::ST_JAM);
  assign tick   = active && (ph_r == 3'(etx_pkg::BIT_CYC - 1));
  assign bo_k   = (tries_r >= 5'(etx_pkg::BO_CAP)) ? 4'(etx_pkg::BO_CAP) : 4'(tries_r + 5'h1);

  // Commands, status and the transmit sequencer
  always_comb begin
    st_nxt    = st_r;
    tmr_nxt   = tmr_r;
    ph_nxt    = tick ? 3'h0 : (active ? ph_r + 3'h1 : 3'h0);
    idx_nxt   = idx_r;
    k_nxt     = k_r;
    bitn_nxt  = bitn_r;
    tries_nxt = tries_r;
    slots_nxt = slots_r;
    crc_nxt   = crc_r;
    blen_nxt  = buf_wr ? blen_r + 11'h1 : blen_r;
    auto_nxt  = auto_r;
    stat_nxt  = stat_r;
    sfull_nxt = status_rd_i ? 1'b0 : sfull_r;
    lfsr_nxt  = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    case (st_r)
      etx_pkg::ST_IDLE: begin
        // The CRC register checks the receive stream while idle
        if (rx_sof_i) begin
          crc_nxt = etx_pkg::CRC_INIT;
        end else if (rx_bit_vld_i) begin
          crc_nxt = crc_step(crc_r, rx_bit_i);
        end
        if (cmd_wr_i && reg_data_i == etx_pkg::CMD_SRC_ON) begin
          auto_nxt = 1'b1;
        end
        if (cmd_wr_i && reg_data_i == etx_pkg::CMD_SRC_OFF) begin
          auto_nxt = 1'b0;
        end
        if (cmd_wr_i && reg_data_i == etx_pkg::CMD_SEND) begin
          if (blen_r > 11'(etx_pkg::MAX_BODY)) begin
            stat_nxt  = etx_pkg::ST_TOO_BIG;
            sfull_nxt = 1'b1;
            blen_nxt  = 11'h0;
          end else begin
            st_nxt    = etx_pkg::ST_DEFER;
            tmr_nxt   = 12'h0;
            tries_nxt = 5'h0;
          end
        end
      end
      etx_pkg::ST_DEFER: begin
        // Any carrier restarts the full gap
        if (carrier_s) begin
          tmr_nxt = 12'h0;
        end else if (tmr_r == 12'(etx_pkg::IFG_CYC - 1)) begin
          st_nxt   = etx_pkg::ST_PRE;
          bitn_nxt = 7'h0;
        end else begin
          tmr_nxt = tmr_r + 12'h1;
        end
      end
      etx_pkg::ST_PRE: begin
        if (tick && bitn_r == 7'(etx_pkg::PRE_BITS - 1)) begin
          st_nxt  = etx_pkg::ST_DATA;
          idx_nxt = 11'h0;
          k_nxt   = 3'h0;
          crc_nxt = etx_pkg::CRC_INIT;
        end else if (tick) begin
          bitn_nxt = bitn_r + 7'h1;
        end
      end
      etx_pkg::ST_DATA: begin
        if (tick) begin
          crc_nxt = crc_step(crc_r, cur_bit);
          k_nxt   = k_r + 3'h1;
          if (k_r == 3'h7) begin
            idx_nxt = idx_r + 11'h1;
            if (idx_r == body_len - 11'h1) begin
              st_nxt   = etx_pkg::ST_FCS;
              bitn_nxt = 7'h0;
            end
          end
        end
      end
      etx_pkg::ST_FCS: begin
        if (tick) begin
          crc_nxt  = {1'b1, crc_r[31:1]};
          bitn_nxt = bitn_r + 7'h1;
          if (bitn_r == 7'(etx_pkg::FCS_BITS - 1)) begin
            st_nxt    = etx_pkg::ST_IDLE;
            stat_nxt  = etx_pkg::ST_OK;
            sfull_nxt = 1'b1;
            blen_nxt  = 11'h0;
          end
        end
      end
      etx_pkg::ST_JAM: begin
        if (tick && bitn_r == 7'(etx_pkg::JAM_BITS - 1)) begin
          tries_nxt = tries_r + 5'h1;
          if (tries_r == 5'(etx_pkg::MAX_TRIES - 1)) begin
            st_nxt    = etx_pkg::ST_IDLE;
            stat_nxt  = etx_pkg::ST_RETRIES;
            sfull_nxt = 1'b1;
            blen_nxt  = 11'h0;
          end else begin
            // Random slot count, range doubling up to the cap
            st_nxt    = etx_pkg::ST_BACK;
            slots_nxt = lfsr_r[9:0] & (10'h3ff >> (4'(etx_pkg::BO_CAP) - bo_k));
            tmr_nxt   = 12'h0;
          end
        end else if (tick) begin
          bitn_nxt = bitn_r + 7'h1;
        end
      end
      etx_pkg::ST_BACK: begin
        // Buffer is untouched, so the retry resends the same frame
        if (slots_r == 10'h0) begin
          st_nxt  = etx_pkg::ST_DEFER;
          tmr_nxt = 12'h0;
        end else if (tmr_r == 12'(etx_pkg::SLOT_CYC - 1)) begin
          tmr_nxt   = 12'h0;
          slots_nxt = slots_r - 10'h1;
        end else begin
          tmr_nxt = tmr_r + 12'h1;
        end
      end
      default: begin
        st_nxt = etx_pkg::ST_IDLE;
      end
    endcase
    // Collision cuts the frame short at once
    if (coll_s && (st_r == etx_pkg::ST_PRE || st_r == etx_pkg::ST_DATA ||
                   st_r == etx_pkg::ST_FCS)) begin
      st_nxt   = etx_pkg::ST_JAM;
      bitn_nxt = 7'h0;
      ph_nxt   = 3'h0;
    end
    // Set wins over a read in the same cycle
    if (stat_nxt != stat_r || st_nxt == etx_pkg::ST_IDLE && st_r != etx_pkg::ST_IDLE) begin
      sfull_nxt = 1'b1;
    end
    // First half inverted, second half true; halves are 3 and 2 cycles
    txen_nxt = active;
    tx_nxt   = active && ((ph_r < 3'(etx_pkg::HALF_CYC)) ? !cur_bit : cur_bit);
  end

  // Registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r   <= 24'h0;
      cnt_r    <= 12'h0;
      dma_on_r <= 1'b0;
      irq_r    <= 1'b0;
      auto_r   <= 1'b1;
      stat_r   <= etx_pkg::ST_OK;
      sfull_r  <= 1'b0;
      blen_r   <= 11'h0;
      st_r     <= etx_pkg::ST_IDLE;
      tmr_r    <= 12'h0;
      ph_r     <= 3'h0;
      idx_r    <= 11'h0;
      k_r      <= 3'h0;
      bitn_r   <= 7'h0;
      tries_r  <= 5'h0;
      slots_r  <= 10'h0;
      crc_r    <= etx_pkg::CRC_INIT;
      lfsr_r   <= etx_pkg::LFSR_SEED;
      tx_r     <= 1'b0;
      txen_r   <= 1'b0;
    end else begin
      addr_r   <= addr_nxt;
      cnt_r    <= cnt_nxt;
      dma_on_r <= dma_on_nxt;
      irq_r    <= irq_nxt;
      auto_r   <= auto_nxt;
      stat_r   <= stat_nxt;
      sfull_r  <= sfull_nxt;
      blen_r   <= blen_nxt;
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      ph_r     <= ph_nxt;
      idx_r    <= idx_nxt;
      k_r      <= k_nxt;
      bitn_r   <= bitn_nxt;
      tries_r  <= tries_nxt;
      slots_r  <= slots_nxt;
      crc_r    <= crc_nxt;
      lfsr_r   <= lfsr_nxt;
      tx_r     <= tx_nxt;
      txen_r   <= txen_nxt;
    end
  end

  // Packet storage, kept until the frame is finished
  always_ff @(posedge ref_clk_i) begin
    if (buf_wr) begin
      buf_r[blen_r] <= f_out_data;
    end
  end

  assign tx_dma_done_irq_o = irq_r;
  assign status_o          = stat_r;
  assign status_full_o     = sfull_r;
  assign src_autofill_o    = auto_r;
  assign dma_addr_o        = addr_r;
  assign tx_o              = tx_r;
  assign tx_en_o           = txen_r;
  assign rx_crc_ok_o       = (crc_r == etx_pkg::CRC_RESIDUE);
endmodule

`default_nettype wire

// *** sim/etx_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module etx_sva (
  // Host side
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_data_i,
  input wire logic        int_enable_wr_i,
  input wire logic        dma_addr_lower_reg_wr_i,
  input wire logic        cmd_wr_i,
  input wire logic        status_rd_i,
  input wire logic        dma_ack_i,
  input wire logic        dma_req_o,
  input wire logic [23:0] dma_addr_o,
  input wire logic        tx_dma_done_irq_o,
  input wire logic [7:0]  status_o,
  input wire logic        status_full_o,
  // Line side
  input wire logic        carrier_i,
  input wire logic        collision_i,
  input wire logic        tx_o,
  input wire logic        tx_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [9:0] quiet_r;   // Idle cycles seen on the raw line
  logic [9:0] quiet_nxt; // Saturates so it never wraps to a small value
  // Raw carrier is used: the design's filter lag can only lengthen the gap
  always_comb begin
    quiet_nxt = (quiet_r == 10'h3ff) ? quiet_r : quiet_r + 10'h001;
    if (carrier_i || tx_en_o) begin
      quiet_nxt = 10'h000;
    end
  end
  // Register only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_r <= 10'h000;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end
  property p_addr_inc;
    dma_req_o && dma_ack_i |=> dma_addr_o == $past(dma_addr_o) + 24'h000001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address did not step");
  property p_addr_load;
    dma_addr_lower_reg_wr_i && !dma_ack_i |=> dma_addr_o[7:0] == $past(reg_data_i);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("low address not loaded");
  property p_ie_off;
    int_enable_wr_i && reg_data_i[2:0] == etx_pkg::IE_OFF |=> !dma_req_o;
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("dma runs after code zero");
  property p_irq_clr;
    int_enable_wr_i |=> !tx_dma_done_irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
  property p_irq_idle;
    tx_dma_done_irq_o |-> !dma_req_o;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("done while dma busy");
  property p_ifg;
    $rose(tx_en_o) |-> $past(quiet_r) >= etx_pkg::IFG_CYC;
  endproperty
  a_ifg: assert property (p_ifg) else $error("frame started without gap");
  property p_manch;
    (tx_en_o && !collision_i && $stable(tx_o)) [*4] |=> !tx_en_o || $changed(tx_o);
  endproperty
  a_manch: assert property (p_manch) else $error("line level held too long");
  property p_big;
    $rose(status_full_o) && status_o == etx_pkg::ST_TOO_BIG
      |-> $past(cmd_wr_i) && $past(reg_data_i) == etx_pkg::CMD_SEND;
  endproperty
  a_big: assert property (p_big) else $error("oversize code without send");
  property p_rd_clr;
    status_rd_i && !tx_en_o && !cmd_wr_i |=> !status_full_o;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("status read not cleared");
  c_irq: cover property ($rose(tx_dma_done_irq_o));
  c_coll: cover property (tx_en_o && collision_i);
  c_big: cover property ($rose(status_full_o) && status_o == etx_pkg::ST_TOO_BIG);
  c_frame: cover property ($fell(tx_en_o));
endmodule
bind ethernet_transmit_mac etx_sva u_etx_sva (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_data_i(reg_data_i),
  .int_enable_wr_i(int_enable_wr_i), .dma_addr_lower_reg_wr_i(dma_addr_lower_reg_wr_i),
  .cmd_wr_i(cmd_wr_i), .status_rd_i(status_rd_i), .dma_ack_i(dma_ack_i),
  .dma_req_o(dma_req_o), .dma_addr_o(dma_addr_o), .tx_dma_done_irq_o(tx_dma_done_irq_o),
  .status_o(status_o), .status_full_o(status_full_o), .carrier_i(carrier_i),
  .collision_i(collision_i), .tx_o(tx_o), .tx_en_o(tx_en_o));
`default_nettype wire

// *** sim/etx_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module etx_partner (
  // Clock, reset and line from the block
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        tx_o,
  input wire logic        tx_en_o,
  // Bench controls: foreign traffic and collision bit
  input wire logic        busy_i,
  input wire logic [11:0] coll_at_i,
  // Transceiver indications
  output logic            carrier_o,
  output logic            collision_o
);
  logic bits_q[$];  // Decoded bits of every burst
  int   lens_q[$];  // Bit count of each burst
  int   bad_halves; // Bits whose two halves matched
  int   coll_cyc;   // Cycles sent while collision shown
  int   ph;
  int   nb;
  logic h1;
  // Own transmission is heard on the shared segment too
  assign carrier_o = busy_i || tx_en_o || collision_o;
  // Bit cells are five cycles, aligned to the start of each burst
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph = 0;
      nb = 0;
      bad_halves = 0;
      coll_cyc = 0;
      collision_o <= 1'b0;
    end else if (!tx_en_o) begin
      if (nb != 0) begin
        lens_q.push_back(nb);
      end
      ph = 0;
      nb = 0;
      collision_o <= 1'b0;
    end else begin
      if (ph == 1) begin
        h1 = tx_o;
      end
      if (ph == 4) begin
        bits_q.push_back(tx_o);
        bad_halves += int'(h1 == tx_o);
        nb++;
      end
      ph = (ph == 4) ? 0 : ph + 1;
      coll_cyc += int'(collision_o);
      // Collide once the chosen bit has gone out
      if (coll_at_i != 12'h000 && nb == int'(coll_at_i)) begin
        collision_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/ethernet_transmit_mac_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ethernet_transmit_mac_bench;
  logic        ref_clk_i, rst_n_i, dma_ack_i, carrier_i, collision_i, busy;
  logic        rx_sof_i, rx_bit_vld_i, rx_bit_i, rx_crc_ok_o, tx_o, tx_en_o;
  logic        tx_dma_done_irq_o, status_full_o, src_autofill_o, dma_req_o;
  logic [7:0]  reg_data_i, wr_sel, dma_data_i, status_o;
  logic [23:0] dma_addr_o;
  logic [11:0] coll_at;
  logic [7:0]  mem [0:2047]; // Host memory image
  int          err_total, compares;
  ethernet_transmit_mac u_ethernet_transmit_mac (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_data_i(reg_data_i),
    .int_enable_wr_i(wr_sel[0]), .dma_addr_upper_reg_wr_i(wr_sel[1]),
    .dma_addr_middle_reg_wr_i(wr_sel[2]), .dma_addr_lower_reg_wr_i(wr_sel[3]),
    .dma_count_high_reg_wr_i(wr_sel[4]), .dma_count_low_reg_wr_i(wr_sel[5]),
    .cmd_wr_i(wr_sel[6]), .status_rd_i(wr_sel[7]), .station_addr_i(48'h02a1b2c3d4e5),
    .tx_dma_done_irq_o(tx_dma_done_irq_o), .status_o(status_o),
    .status_full_o(status_full_o), .src_autofill_o(src_autofill_o),
    .dma_req_o(dma_req_o), .dma_addr_o(dma_addr_o), .dma_ack_i(dma_ack_i),
    .dma_data_i(dma_data_i), .carrier_i(carrier_i), .collision_i(collision_i),
    .tx_o(tx_o), .tx_en_o(tx_en_o), .rx_sof_i(rx_sof_i), .rx_bit_vld_i(rx_bit_vld_i),
    .rx_bit_i(rx_bit_i), .rx_crc_ok_o(rx_crc_ok_o));
  etx_partner u_etx_partner (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tx_o(tx_o), .tx_en_o(tx_en_o),
    .busy_i(busy), .coll_at_i(coll_at), .carrier_o(carrier_i), .collision_o(collision_i));
  always #10 ref_clk_i = ~ref_clk_i;
  // Host memory answers every other cycle, so data always matches a settled address
  always @(posedge ref_clk_i) begin
    dma_ack_i  <= dma_req_o && !dma_ack_i;
    dma_data_i <= mem[dma_addr_o[10:0]];
  end
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe: 0 irq code, 1-3 address, 4-5 count, 6 command, 7 status read
  task automatic wr(input int s, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_sel     <= 8'h01 << s;
    reg_data_i <= d;
    @(posedge ref_clk_i);
    wr_sel <= 8'h00;
    #1;
  endtask
  task automatic dma(input logic [23:0] a, input logic [11:0] n);
    wr(0, 8'h00);
    wr(1, a[23:16]);
    wr(2, a[15:8]);
    wr(3, a[7:0]);
    wr(4, {4'hf, n[11:8]});
    wr(5, n[7:0]);
    wr(0, 8'h06);
  endtask
  // Bounded wait: 0 done irq, 1 status full, 2 two bursts seen; a miss is a mismatch
  task automatic wt(input int m);
    bit hit;
    hit = 1'b0;
    for (int k = 0; k < 20000 && !hit; k++) begin
      hit = (m == 0 && tx_dma_done_irq_o === 1'b1) || (m == 1 && status_full_o === 1'b1)
            || (m == 2 && u_etx_partner.lens_q.size() >= 2);
      if (!hit) begin
        @(posedge ref_clk_i);
        #1;
      end
    end
    if (!hit) begin
      err_total++;
      $display("BAD t=%0t wait %0d timed out", $time, m);
    end
    // Two more edges so the line model has closed the burst that just ended
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  // Rebuilds the frame body, pad and check word, compares line bits after preamble
  task automatic chk_frame(input int base, input int len, input bit af, input int off);
    logic [7:0]  b;
    logic [31:0] c;
    int          n;
    int          bad;
    n = (len < 60) ? 60 : len;
    c = etx_pkg::CRC_INIT;
    bad = 0;
    for (int i = 0; i < n + 4; i++) begin
      if (i >= n) begin
        b = ~c[8*(i-n) +: 8];
      end else if (af && i >= 6 && i < 12) begin
        b = u_ethernet_transmit_mac.station_addr_i[8*(11-i) +: 8];
      end else begin
        b = (i < len) ? mem[base+i] : 8'h00;
      end
      for (int j = 0; j < 8; j++) begin
        bad += int'(u_etx_partner.bits_q[off+64+8*i+j] !== b[j]);
        if (i < n) begin
          c = (c >> 1) ^ ((c[0] ^ b[j]) ? etx_pkg::CRC_POLY : 32'h0);
        end
      end
    end
    chk(bad, 0);
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    err_total++;
    wrap_up();
  end
  initial begin
    {ref_clk_i, rst_n_i, busy, rx_sof_i, rx_bit_vld_i, rx_bit_i} = '0;
    {reg_data_i, wr_sel, coll_at} = '0;
    err_total = 0;
    compares = 0;
    for (int k = 0; k < 2048; k++) mem[k] = 8'(k * 37); // Dest, source, type
    for (int k = 0; k < 6; k++) mem[12'h4f0 + k] = 8'hff; // Broadcast destination
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(status_o, 0);
    chk(src_autofill_o, 1);
    dma(24'h1234f0, 12'd20);
    wt(0);
    chk(tx_dma_done_irq_o, 1);
    chk(dma_addr_o, 24'h123504);
    busy <= 1'b1;
    wr(6, 8'h29);
    dma(24'h123600, 12'd64);
    repeat (40) @(posedge ref_clk_i);
    #1;
    chk(dma_addr_o, 24'h123608);
    chk(dma_req_o, 0);
    repeat (300) @(posedge ref_clk_i);
    busy <= 1'b0;
    wt(1);
    chk(status_o, 0);
    chk(u_etx_partner.lens_q[0], 576);
    chk(u_etx_partner.bad_halves, 0);
    chk_frame(12'h4f0, 20, 1'b1, 0);
    wr(7, 8'h00);
    chk(status_full_o, 0);
    wt(0);
    chk(dma_addr_o, 24'h123640);
    wr(6, 8'h2b);
    chk(src_autofill_o, 0);
    coll_at <= 12'd100;
    wr(6, 8'h29);
    wt(2);
    coll_at <= 12'd0;
    wt(1);
    chk(status_o, 0);
    chk(u_etx_partner.coll_cyc >= 190 && u_etx_partner.coll_cyc <= 250, 1);
    chk(u_etx_partner.lens_q[2], 608);
    chk_frame(12'h600, 64, 1'b0, 576 + u_etx_partner.lens_q[1]);
    wr(7, 8'h00);
    wr(6, 8'h2a);
    chk(src_autofill_o, 1);
    dma(24'h000000, 12'd1515);
    wt(0);
    wr(6, 8'h29);
    wt(1);
    chk(status_o, 5);
    chk(u_etx_partner.lens_q.size(), 3);
    // Replay the first frame's body and check word into the receive checker
    @(posedge ref_clk_i);
    rx_sof_i <= 1'b1;
    for (int i = 64; i < 576; i++) begin
      @(posedge ref_clk_i);
      rx_sof_i     <= 1'b0;
      rx_bit_vld_i <= 1'b1;
      rx_bit_i     <= u_etx_partner.bits_q[i];
    end
    @(posedge ref_clk_i);
    rx_bit_vld_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk(rx_crc_ok_o, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
